// >>> design/fsr_pkg.sv
package fsr_pkg;

    // opcodes
    localparam logic [7:0] OP_READ_SR1 = 8'h05;
    localparam logic [7:0] OP_READ_SR2 = 8'h35;
    localparam logic [7:0] OP_READ_SR3 = 8'h15;
    localparam logic [7:0] OP_WRITE_SR1 = 8'h01;
    localparam logic [7:0] OP_WRITE_SR2 = 8'h31;
    localparam logic [7:0] OP_WRITE_SR3 = 8'h11;
    localparam logic [7:0] OP_WRITE_EN = 8'h06;
    localparam logic [7:0] OP_WRITE_DIS = 8'h04;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] OP_SEC_PROG = 8'h42;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;

    // bit positions, first status register
    localparam int SR1_GUARD_LOWER = 7;
    localparam int SR1_BP_LSB = 2;
    localparam int SR1_WEL = 1;
    localparam int SR1_BUSY = 0;
    // bit positions, second status register
    localparam int SR2_ERASE_SUS = 7;
    localparam int SR2_COMPLEMENT = 6;
    localparam int SR2_LOCK_LSB = 3;
    localparam int SR2_PROG_SUS = 2;
    localparam int SR2_QUAD = 1;
    localparam int SR2_GUARD_UPPER = 0;
    // bit positions, third status register
    localparam int SR3_DRV_LSB = 5;

    // values after reset
    localparam logic [1:0] DRV_RESET = 2'h3;
    localparam logic [4:0] BP_RESET = 5'h00;
    localparam logic [2:0] LOCK_RESET = 3'h0;
    // idle pin levels {cs_n, sck, si, wp_n}
    localparam logic [3:0] PINS_IDLE = 4'h9;

    // frame geometry: exactly opcode plus one data byte for a status write
    localparam logic [2:0] WSR_BYTES = 3'h2;

    // self-timed status write cycle
    localparam int CLK_MHZ = 250;
    localparam int WSR_TIME_NS = 2000;
    localparam int WSR_CYCLES = (WSR_TIME_NS * CLK_MHZ) / 1000;
    localparam int WSR_CW = 12;

    typedef struct packed {
        logic protect_granularity_select;
        logic protect_top_bottom_select;
        logic protect_amount_2;
        logic protect_amount_1;
        logic protect_amount_0;
    } fsr_bp_s;

    typedef struct packed {
        logic status_guard_upper;
        logic status_guard_lower;
        fsr_bp_s bp;
        logic protect_complement;
        logic otp_page_lock_c;
        logic otp_page_lock_b;
        logic otp_page_lock_a;
        logic quad_io_enable;
        logic [1:0] output_drive_level;
    } fsr_cfg_s;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
    } fsr_pins_s;

endpackage

// >>> design/fsr_sync.sv
`timescale 1ns/1ps
module fsr_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // first stage feeds only the second stage; reset to the idle pin level
    // so no false edge follows reset
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        logic meta_bit_reg;
        logic out_bit_reg;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_bit_reg <= INIT[i];
                out_bit_reg <= INIT[i];
            end else begin
                meta_bit_reg <= d[i];
                out_bit_reg <= meta_bit_reg;
            end
        end
        assign q[i] = out_bit_reg;
    end
endmodule

// >>> design/fsr_status_regs.sv
`timescale 1ns/1ps
// Behaviour
// R1 - opcode 15h streams third status register
// R2 - after bit 0, restart at bit 7
// R3 - every repeat shows live register values
// R4 - chip select high ends read, output floats
// R5 - bit 7 second register: erase suspended
// R6 - bit 6: complement inverts protected region
// R7 - bits 5:3 lock security pages, sticky
// R8 - program suspended flag, read only
// R9 - quad enable turns hold, wp into data
// R10 - status writes skip read-only flag bits
// R11 - drive level bits 6:5, reset 11
// R12 - guards 00: write needs write-enable latch
// R13 - guards 01: low wp locks writes
// R14 - guards 10: locked until power cycle
// R15 - block-protect fields: granularity, side, amount
// R16 - latch clear: program, erase, write ignored
// R17 - latch zero after power-up or reset
// R18 - latch clears when gated operations end
// R19 - incomplete opcode abort keeps the latch
// R20 - busy flag high during self-timed work
// R21 - host polls busy within one read
// R22 - opcode 35h streams second status register
// R23 - first register: bit1 latch, bit0 busy
// R24 - status write needs exactly 16 bits
// R25 - msb first, changes on falling clock
// R26 - reserved third-register bits read zero
module fsr_status_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    input wire logic core_busy,
    input wire logic erase_suspended_flag,
    input wire logic program_suspended_flag,
    output logic so,
    output logic so_oe,
    output logic op_start,
    output logic [7:0] op_code,
    output fsr_pkg::fsr_cfg_s cfg
);
    typedef struct packed {
        logic so;
        logic so_oe;
        logic cs_d;
        logic sck_d;
        logic core_busy_d;
        logic [7:0] shift;
        logic [7:0] cmd;
        logic [2:0] phase;
        logic [2:0] byte_idx;
        logic [3:0] page;
        logic [7:0] data;
        logic write_enable_latch;
        logic wsr_busy;
        logic [fsr_pkg::WSR_CW-1:0] wsr_cnt;
        logic op_start;
        logic [7:0] op_code;
        fsr_pkg::fsr_cfg_s cfg;
    } fsr_state_s;

    fsr_state_s r_reg, r_next;
    fsr_pkg::fsr_pins_s pins;
    logic rst_meta_reg, rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n <= rst_meta_reg;
        end
    end

    fsr_sync #(.W(4), .INIT(fsr_pkg::PINS_IDLE)) u_sync (
        .clk(clk),
        .rst_n(rst_sync_n),
        .d({cs_n, sck, si, wp_n}),
        .q(pins)
    );

    function automatic logic is_gated_op(input logic [7:0] c);
        is_gated_op = (c == fsr_pkg::OP_PAGE_PROG) || (c == fsr_pkg::OP_ERASE_4K)
            || (c == fsr_pkg::OP_ERASE_32K) || (c == fsr_pkg::OP_ERASE_64K)
            || (c == fsr_pkg::OP_CHIP_ERASE_A) || (c == fsr_pkg::OP_CHIP_ERASE_B)
            || (c == fsr_pkg::OP_SEC_PROG) || (c == fsr_pkg::OP_SEC_ERASE);
    endfunction

    function automatic logic is_wsr_op(input logic [7:0] c);
        is_wsr_op = (c == fsr_pkg::OP_WRITE_SR1) || (c == fsr_pkg::OP_WRITE_SR2)
            || (c == fsr_pkg::OP_WRITE_SR3);
    endfunction

    logic busy, wp_eff, cs_rise, sck_rise, sck_fall, core_fall, frame_on;
    logic wsr_allowed, page_locked, live_bit;
    logic [7:0] sr1, sr2, sr3, new_byte;

    // quad mode turns wp into a data line, so it no longer guards
    assign wp_eff = r_reg.cfg.quad_io_enable | pins.wp_n; // R9
    assign busy = r_reg.wsr_busy | core_busy; // R20
    assign frame_on = !pins.cs_n;
    assign cs_rise = pins.cs_n & !r_reg.cs_d;
    assign sck_rise = frame_on & pins.sck & !r_reg.sck_d;
    assign sck_fall = frame_on & !pins.sck & r_reg.sck_d;
    assign core_fall = r_reg.core_busy_d & !core_busy;
    assign new_byte = {r_reg.shift[6:0], pins.si};

    // registers are assembled live from the stored bits and the busy and suspend flag inputs each time
    always_comb begin
        sr1 = '0;
        sr1[fsr_pkg::SR1_GUARD_LOWER] = r_reg.cfg.status_guard_lower;
        sr1[fsr_pkg::SR1_BP_LSB +: 5] = r_reg.cfg.bp; // R15
        sr1[fsr_pkg::SR1_WEL] = r_reg.write_enable_latch; // R23
        sr1[fsr_pkg::SR1_BUSY] = busy; // R23
        sr2 = '0;
        sr2[fsr_pkg::SR2_ERASE_SUS] = erase_suspended_flag; // R5
        sr2[fsr_pkg::SR2_COMPLEMENT] = r_reg.cfg.protect_complement; // R6
        sr2[fsr_pkg::SR2_LOCK_LSB +: 3] = {r_reg.cfg.otp_page_lock_c,
            r_reg.cfg.otp_page_lock_b, r_reg.cfg.otp_page_lock_a}; // R7
        sr2[fsr_pkg::SR2_PROG_SUS] = program_suspended_flag; // R8
        sr2[fsr_pkg::SR2_QUAD] = r_reg.cfg.quad_io_enable;
        sr2[fsr_pkg::SR2_GUARD_UPPER] = r_reg.cfg.status_guard_upper;
        sr3 = '0; // R26
        sr3[fsr_pkg::SR3_DRV_LSB +: 2] = r_reg.cfg.output_drive_level; // R11
    end

    always_comb begin
        unique case (r_reg.cmd)
            fsr_pkg::OP_READ_SR1: live_bit = sr1[~r_reg.phase];
            fsr_pkg::OP_READ_SR2: live_bit = sr2[~r_reg.phase]; // R22
            fsr_pkg::OP_READ_SR3: live_bit = sr3[~r_reg.phase]; // R1
            default: live_bit = 1'b0;
        endcase
    end

    always_comb begin
        unique case ({r_reg.cfg.status_guard_upper, r_reg.cfg.status_guard_lower})
            2'b00: wsr_allowed = 1'b1; // R12
            2'b01: wsr_allowed = wp_eff; // R13
            default: wsr_allowed = 1'b0; // R14
        endcase
    end

    always_comb begin
        unique case (r_reg.page)
            4'h1: page_locked = r_reg.cfg.otp_page_lock_a; // R7
            4'h2: page_locked = r_reg.cfg.otp_page_lock_b;
            4'h3: page_locked = r_reg.cfg.otp_page_lock_c;
            default: page_locked = 1'b0;
        endcase
    end

    logic rd_cmd;
    assign rd_cmd = (r_reg.cmd == fsr_pkg::OP_READ_SR1) || (r_reg.cmd == fsr_pkg::OP_READ_SR2)
        || (r_reg.cmd == fsr_pkg::OP_READ_SR3);

    always_comb begin
        r_next = r_reg;
        r_next.cs_d = pins.cs_n;
        r_next.sck_d = pins.sck;
        r_next.core_busy_d = core_busy;
        r_next.op_start = 1'b0;
        if (pins.cs_n) begin
            r_next.so_oe = 1'b0; // R4
            r_next.phase = '0;
            r_next.byte_idx = '0;
        end
        if (sck_rise) begin
            r_next.shift = new_byte;
            r_next.phase = r_reg.phase + 3'h1; // R2
            if (r_reg.phase == 3'h7) begin
                if (r_reg.byte_idx != 3'h7) begin
                    r_next.byte_idx = r_reg.byte_idx + 3'h1;
                end
                if (r_reg.byte_idx == 3'h0) begin
                    r_next.cmd = new_byte;
                end
                if (r_reg.byte_idx == 3'h1) begin
                    r_next.data = new_byte;
                end
                if (r_reg.byte_idx == 3'h2) begin
                    r_next.page = new_byte[7:4];
                end
            end
        end
        // output bit changes on the falling edge so the host samples it on rising
        if (sck_fall && rd_cmd && r_reg.byte_idx != 3'h0) begin
            r_next.so = live_bit; // R3 R25
            r_next.so_oe = 1'b1;
        end
        if (core_fall) begin
            r_next.write_enable_latch = 1'b0; // R18
        end
        if (r_reg.wsr_busy) begin
            if (r_reg.wsr_cnt == fsr_pkg::WSR_CW'(fsr_pkg::WSR_CYCLES - 1)) begin
                r_next.wsr_busy = 1'b0;
                r_next.write_enable_latch = 1'b0; // R18
            end else begin
                r_next.wsr_cnt = r_reg.wsr_cnt + fsr_pkg::WSR_CW'(1);
            end
        end
        // a frame shorter than one opcode never touches the latch
        if (cs_rise && r_reg.byte_idx != 3'h0) begin // R19
            if (r_reg.cmd == fsr_pkg::OP_WRITE_EN && !busy) begin
                r_next.write_enable_latch = 1'b1;
            end else if (r_reg.cmd == fsr_pkg::OP_WRITE_DIS && !busy) begin
                r_next.write_enable_latch = 1'b0; // R18
            end else if (is_wsr_op(r_reg.cmd) && r_reg.write_enable_latch) begin // R16
                if (r_reg.byte_idx == fsr_pkg::WSR_BYTES && r_reg.phase == 3'h0
                    && wsr_allowed && !busy) begin // R24
                    r_next.wsr_busy = 1'b1;
                    r_next.wsr_cnt = '0;
                    unique case (r_reg.cmd)
                        fsr_pkg::OP_WRITE_SR1: begin
                            r_next.cfg.status_guard_lower =
                                r_reg.data[fsr_pkg::SR1_GUARD_LOWER];
                            r_next.cfg.bp = r_reg.data[fsr_pkg::SR1_BP_LSB +: 5];
                        end
                        fsr_pkg::OP_WRITE_SR2: begin // R10
                            r_next.cfg.protect_complement =
                                r_reg.data[fsr_pkg::SR2_COMPLEMENT];
                            // lock bits are one-time: a written 0 cannot undo a 1
                            r_next.cfg.otp_page_lock_c = r_reg.cfg.otp_page_lock_c
                                | r_reg.data[fsr_pkg::SR2_LOCK_LSB + 2];
                            r_next.cfg.otp_page_lock_b = r_reg.cfg.otp_page_lock_b
                                | r_reg.data[fsr_pkg::SR2_LOCK_LSB + 1];
                            r_next.cfg.otp_page_lock_a = r_reg.cfg.otp_page_lock_a
                                | r_reg.data[fsr_pkg::SR2_LOCK_LSB];
                            r_next.cfg.quad_io_enable = r_reg.data[fsr_pkg::SR2_QUAD];
                            r_next.cfg.status_guard_upper =
                                r_reg.data[fsr_pkg::SR2_GUARD_UPPER];
                        end
                        default: begin
                            r_next.cfg.output_drive_level =
                                r_reg.data[fsr_pkg::SR3_DRV_LSB +: 2]; // R26
                        end
                    endcase
                end else begin
                    r_next.write_enable_latch = 1'b0; // R18 R24
                end
            end else if (is_gated_op(r_reg.cmd) && r_reg.write_enable_latch) begin // R16
                if (!busy && !(r_reg.cmd == fsr_pkg::OP_SEC_PROG && page_locked)
                    && !(r_reg.cmd == fsr_pkg::OP_SEC_ERASE && page_locked)) begin
                    r_next.op_start = 1'b1;
                    r_next.op_code = r_reg.cmd;
                end else begin
                    r_next.write_enable_latch = 1'b0; // R18
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r_reg <= '0; // R17
            r_reg.cs_d <= 1'b1;
            r_reg.cfg.bp <= fsr_pkg::BP_RESET;
            r_reg.cfg.output_drive_level <= fsr_pkg::DRV_RESET; // R11
            // power cycle drops a lock-down back to guards 00
            r_reg.cfg.status_guard_upper <= 1'b0; // R14
            r_reg.cfg.status_guard_lower <= 1'b0;
            r_reg.cfg.otp_page_lock_a <= fsr_pkg::LOCK_RESET[0];
        end else begin
            r_reg <= r_next;
        end
    end

    assign so = r_reg.so;
    assign so_oe = r_reg.so_oe;
    assign op_start = r_reg.op_start;
    assign op_code = r_reg.op_code;
    assign cfg = r_reg.cfg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    so_release_a: assert property (pins.cs_n |=> !so_oe) // R4
        else $error("serial output still driven after chip select high");
    so_live_a: assert property (sck_fall && rd_cmd && r_reg.byte_idx != 3'h0
        |=> so_oe && so == $past(live_bit)) // R3
        else $error("status bit not the live value");
    so_msb_a: assert property (sck_fall && r_reg.cmd == fsr_pkg::OP_READ_SR3
        && r_reg.byte_idx == 3'h1 && r_reg.phase == 3'h0 |=> so == $past(sr3[7])) // R25
        else $error("third register read did not start at bit 7");
    phase_wrap_a: assert property (sck_rise && r_reg.phase == 3'h7 |=> r_reg.phase == 3'h0) // R2
        else $error("bit position did not wrap");
    wsr_wel_a: assert property ($rose(r_reg.wsr_busy) |-> $past(r_reg.write_enable_latch)) // R12
        else $error("status write ran without write enable");
    wsr_wp_a: assert property ($rose(r_reg.wsr_busy) && $past(sr1[7]) |-> $past(wp_eff)
        && !$past(r_reg.cfg.status_guard_upper)) // R13
        else $error("status write ran while hardware protected");
    wsr_lockdown_a: assert property ($rose(r_reg.wsr_busy) |->
        !$past(r_reg.cfg.status_guard_upper)) // R14
        else $error("status write ran under lock-down");
    wsr_length_a: assert property ($rose(r_reg.wsr_busy) |->
        $past(r_reg.byte_idx) == 3'h2 && $past(r_reg.phase) == 3'h0) // R24
        else $error("status write accepted with wrong bit count");
    wsr_end_a: assert property ($fell(r_reg.wsr_busy) |-> !r_reg.write_enable_latch) // R18
        else $error("latch still set after status write");
    busy_flag_a: assert property (r_reg.wsr_busy || core_busy |-> sr1[0]) // R20
        else $error("busy flag low during self-timed work");
    op_gate_a: assert property (op_start |-> $past(r_reg.write_enable_latch)) // R16
        else $error("operation started with latch clear");
    wel_keep_a: assert property (cs_rise && r_reg.byte_idx == 3'h0 && !core_fall
        && !r_reg.wsr_busy |=> r_reg.write_enable_latch == $past(r_reg.write_enable_latch)) // R19
        else $error("latch changed on incomplete opcode");

    sr3_wrap_c: cover property (sck_rise && r_reg.cmd == fsr_pkg::OP_READ_SR3
        && r_reg.byte_idx == 3'h2 && r_reg.phase == 3'h7);
    wsr_done_c: cover property ($fell(r_reg.wsr_busy));
    op_start_c: cover property (op_start);
    busy_poll_c: cover property (frame_on && r_reg.cmd == fsr_pkg::OP_READ_SR1
        && $fell(r_reg.wsr_busy));
endmodule

// >>> sim/fsr_host.sv
`timescale 1ns/1ps
module fsr_host (
    input wire logic clk,
    input wire logic so,
    input wire logic so_oe,
    output fsr_pkg::fsr_pins_s pins
);
    initial pins = 4'h9;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic set_wp(input logic v);
        pins.wp_n = v;
    endtask

    // mode 0: sck rests low between frames; si flips after use so a stale
    // level never passes for data
    task automatic frame(input logic [31:0] tx, input int ntx, input int nrx,
        output logic [63:0] rx);
        rx = 64'h0000_0000_0000_0000;
        pins.cs_n = 1'b0;
        tick(10);
        for (int i = 0; i < ntx + nrx; i++) begin
            pins.si = (i < ntx) ? tx[31 - i] : ~pins.si;
            tick(10);
            pins.sck = 1'b1;
            if (i >= ntx) begin
                rx = {rx[62:0], so_oe ? so : 1'bx};
            end
            tick(10);
            pins.sck = 1'b0;
        end
        tick(5);
        pins.cs_n = 1'b1;
        pins.si = ~pins.si;
        tick(10);
    endtask
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk;
    logic rst_n;
    logic core_busy;
    logic erase_suspended_flag;
    logic program_suspended_flag;
    logic so;
    logic so_oe;
    logic op_start;
    logic [7:0] op_code;
    logic [7:0] last_op;
    fsr_pkg::fsr_cfg_s cfg;
    fsr_pkg::fsr_pins_s pins;
    int num_errors = 0;
    int check_count = 0;
    int starts = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    fsr_host host_u (.clk(clk), .so(so), .so_oe(so_oe), .pins(pins));

    fsr_status_regs dut_u (.clk(clk), .rst_n(rst_n), .cs_n(pins.cs_n), .sck(pins.sck),
        .si(pins.si), .wp_n(pins.wp_n), .core_busy(core_busy),
        .erase_suspended_flag(erase_suspended_flag),
        .program_suspended_flag(program_suspended_flag), .so(so), .so_oe(so_oe),
        .op_start(op_start), .op_code(op_code), .cfg(cfg));

    always @(posedge clk) begin
        if (op_start === 1'b1) begin
            starts++;
            last_op = op_code;
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            end_of_test;
        end
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] rd_op(input int n);
        return (n == 1) ? fsr_pkg::OP_READ_SR1 :
            (n == 2) ? fsr_pkg::OP_READ_SR2 : fsr_pkg::OP_READ_SR3;
    endfunction

    task automatic sr(input int n, input logic [7:0] exp, input string what);
        logic [63:0] r;
        host_u.frame({rd_op(n), 24'h00_0000}, 8, 8, r);
        chk(what, 64'(exp), 64'(r[7:0]));
    endtask

    task automatic wren;
        logic [63:0] r;
        host_u.frame({fsr_pkg::OP_WRITE_EN, 24'h00_0000}, 8, 0, r);
    endtask

    // one long read: the busy bit must fall while clocks keep running
    task automatic poll(output logic [63:0] r);
        host_u.frame({fsr_pkg::OP_READ_SR1, 24'h00_0000}, 8, 64, r);
        chk("busy_at_end", 64'h0, 64'(r[0]));
    endtask

    task automatic wsr(input int n, input logic [7:0] d, input int bits);
        logic [63:0] r;
        logic [7:0] op;
        op = (n == 1) ? fsr_pkg::OP_WRITE_SR1 :
            (n == 2) ? fsr_pkg::OP_WRITE_SR2 : fsr_pkg::OP_WRITE_SR3;
        wren;
        host_u.frame({op, d, 16'h0000}, bits, 0, r);
        poll(r);
    endtask

    task automatic do_reset;
        rst_n = 1'b0;
        host_u.tick(2);
        rst_n = 1'b1;
        host_u.tick(8);
    endtask

    task automatic t_reset;
        logic [63:0] r;
        sr(1, 8'h00, "sr1_reset");
        sr(2, 8'h00, "sr2_reset");
        host_u.frame({fsr_pkg::OP_READ_SR3, 24'h00_0000}, 8, 16, r);
        chk("sr3_twice", 64'h6060, r);
        host_u.frame({fsr_pkg::OP_READ_SR3, 24'h00_0000}, 8, 3, r);
        chk("so_oe_released", 64'h0, 64'(so_oe));
        $display("test reset done");
    endtask

    task automatic t_gate;
        logic [63:0] r;
        logic [1:0] v;
        host_u.frame({fsr_pkg::OP_WRITE_SR2, 8'hff, 16'h0000}, 16, 0, r);
        sr(2, 8'h00, "sr2_unlatched");
        wren;
        host_u.frame({fsr_pkg::OP_WRITE_SR2, 24'h00_0000}, 4, 0, r);
        sr(1, 8'h02, "latch_kept");
        host_u.frame({fsr_pkg::OP_WRITE_SR3, 8'h9f, 16'h0000}, 16, 0, r);
        poll(r);
        chk("busy_first", 64'h03, 64'(r[63:56]));
        chk("latch_end", 64'h00, 64'(r[7:0]));
        sr(3, 8'h00, "sr3_full_drive");
        for (int k = 1; k < 4; k++) begin
            v = 2'(k);
            wsr(3, {1'b1, v, 5'h1f}, 16);
            sr(3, {1'b0, v, 5'h00}, "sr3_drive");
            chk("drive_level", 64'(v), 64'(cfg.output_drive_level));
        end
        $display("test gate done");
    endtask

    task automatic t_flags;
        erase_suspended_flag = 1'b1;
        program_suspended_flag = 1'b1;
        wsr(2, 8'h42, 16);
        sr(2, 8'hc6, "sr2_flags_set");
        chk("cmp_qe", 64'h3, 64'({cfg.protect_complement, cfg.quad_io_enable}));
        erase_suspended_flag = 1'b0;
        program_suspended_flag = 1'b0;
        sr(2, 8'h42, "sr2_flags_clear");
        wsr(2, 8'h84, 16);
        sr(2, 8'h00, "sr2_ro_kept");
        $display("test flags done");
    endtask

    task automatic t_guard;
        wsr(1, 8'hff, 16);
        sr(1, 8'hfc, "sr1_guard_bp");
        chk("cfg_bp", 64'h1f, 64'(cfg.bp));
        host_u.set_wp(1'b0);
        wsr(1, 8'h00, 16);
        sr(1, 8'hfc, "sr1_wp_locked");
        host_u.set_wp(1'b1);
        wsr(1, 8'h00, 16);
        sr(1, 8'h00, "sr1_wp_open");
        wsr(2, 8'h01, 16);
        wsr(2, 8'h00, 16);
        sr(2, 8'h01, "sr2_lockdown");
        wren;
        do_reset;
        sr(2, 8'h00, "sr2_power_cycle");
        sr(1, 8'h00, "latch_after_reset");
        wsr(2, 8'h40, 12);
        sr(2, 8'h00, "sr2_short_write");
        sr(1, 8'h00, "latch_short_write");
        $display("test guard done");
    endtask

    task automatic t_ops;
        logic [7:0] ops [8] = '{fsr_pkg::OP_PAGE_PROG, fsr_pkg::OP_ERASE_4K,
            fsr_pkg::OP_ERASE_32K, fsr_pkg::OP_ERASE_64K, fsr_pkg::OP_CHIP_ERASE_A,
            fsr_pkg::OP_CHIP_ERASE_B, fsr_pkg::OP_SEC_PROG, fsr_pkg::OP_SEC_ERASE};
        logic [63:0] r;
        int n;
        int base;
        for (int k = 0; k < 8; k++) begin
            n = (k == 4 || k == 5) ? 8 : 32;
            base = starts;
            host_u.frame({ops[k], 24'h00_0000}, n, 0, r);
            chk("start_unlatched", 64'(base), 64'(starts));
            wren;
            host_u.frame({ops[k], 24'h00_0000}, n, 0, r);
            chk("start_latched", 64'(base + 1), 64'(starts));
            chk("op_code", 64'(ops[k]), 64'(last_op));
            core_busy = 1'b1;
            sr(1, 8'h03, "sr1_core_busy");
            core_busy = 1'b0;
            sr(1, 8'h00, "sr1_after_op");
        end
        wsr(2, 8'h08, 16);
        sr(2, 8'h08, "sr2_lock_a");
        base = starts;
        wren;
        host_u.frame({fsr_pkg::OP_SEC_PROG, 24'h00_1000}, 32, 0, r);
        chk("sec_prog_locked", 64'(base), 64'(starts));
        sr(1, 8'h00, "latch_after_refusal");
        $display("test ops done");
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        core_busy = 1'b0;
        erase_suspended_flag = 1'b0;
        program_suspended_flag = 1'b0;
        #1;
        do_reset;
        t_reset;
        t_gate;
        t_flags;
        t_guard;
        t_ops;
        end_of_test;
    end
endmodule
